// ==== tcm_pkg.sv ====
// Operation
// - Unequipped: bits 3-8 zero, five frames
// - AIS: bit 4 set, five frames
// - Multiframe loss: four bad, three good
// - Trace lock-loss while message unaligned
// - Mismatch: stable message differs one period
// - Mismatch clears on relock to match
// - ODI: bit 7 frame 74, five times
// - RDI: bit 8 frame 73, five times
// - Status bit 0 unused, driven zero
// - Parity counter, enabled, two per frame
// - Block mode counts one per frame
// - Counters saturate, clear on read
// - Remote error counter on bit 5
// - Outgoing error counter on bit 6
// - V4 byte captured when enabled
package tcm_pkg;
    localparam int NPORT = 4;                           // Ports
    localparam logic [2:0] PERSIST_FRAMES = 3'h5;       // Alarm persistence
    localparam logic [2:0] LOM_SET_CNT    = 3'h4;       // Bad multiframes
    localparam logic [2:0] LOM_CLR_CNT    = 3'h3;       // Good multiframes
    localparam logic [11:0] MFAS_PAT      = 12'hFFE;    // Alignment pattern
    localparam logic [6:0] FAS_FIRST      = 7'h01;      // Alignment frames
    localparam logic [6:0] FAS_LAST       = 7'h08;
    localparam logic [6:0] TRACE_FIRST    = 7'h09;      // Trace frames
    localparam logic [6:0] TRACE_LAST     = 7'h48;
    localparam logic [6:0] RDI_POS        = 7'h49;      // Frame 73
    localparam logic [6:0] ODI_POS        = 7'h4A;      // Frame 74
    // N2 bit positions (bit 1 is MSB)
    localparam int N2_BIP_HI = 7;
    localparam int N2_BIP_LO = 6;
    localparam int N2_UNEQ_HI = 5;
    localparam int N2_AIS = 4;
    localparam int N2_REI = 3;
    localparam int N2_OEI = 2;
    localparam int N2_ODI = 1;
    localparam int N2_RDI = 0;
    // Status bit positions
    localparam int ST_UNEQ = 7;
    localparam int ST_AIS = 6;
    localparam int ST_LOM = 5;
    localparam int ST_LOL = 4;
    localparam int ST_TIM = 3;
    localparam int ST_ODI = 2;
    localparam int ST_RDI = 1;
    localparam logic [7:0] CNT_MAX  = 8'hFF;            // Saturation
    localparam logic [7:0] REG_RST  = 8'h00;            // Reset values
    localparam logic [2:0] PCNT_RST = 3'h0;
    typedef logic [11:0] tcm_addr_t;
    typedef logic [7:0] tcm_byte_t;
    // Register offsets per port
    localparam tcm_addr_t STATUS_ADDR [NPORT] = '{12'h05D, 12'h08D, 12'h0BD, 12'h0ED};
    localparam tcm_addr_t PARITY_ADDR [NPORT] = '{12'h180, 12'h280, 12'h380, 12'h480};
    localparam tcm_addr_t REMOTE_ADDR [NPORT] = '{12'h181, 12'h281, 12'h381, 12'h481};
    localparam tcm_addr_t OUTGO_ADDR  [NPORT] = '{12'h182, 12'h282, 12'h382, 12'h482};
    localparam tcm_addr_t V4_ADDR     [NPORT] = '{12'h196, 12'h296, 12'h396, 12'h496};
    typedef enum logic [1:0] {
        TR_HUNT    = 2'h0,
        TR_CONFIRM = 2'h1,
        TR_LOCKED  = 2'h3
    } tcm_trace_state_t;
endpackage : tcm_pkg

// ==== tcm_trace_if.sv ====
`timescale 1ns/1ns
// Carries one port's trace bits to the trace aligner
interface tcm_trace_if (
    input wire logic clk,      // Byte clock
    input wire logic reset_n   // Async reset
);
    logic         frame_stb;   // One N2 byte this cycle
    logic [6:0]   mf_pos;      // Multiframe position 1..76
    logic [1:0]   tc_bits;     // N2 bits 7 and 8
    logic         mf_lost;     // Multiframe loss alarm
    logic [127:0] expected;    // Comparison message
    logic         lock;        // Trace locked
    logic         mismatch;    // Trace mismatch alarm
    modport mon (input clk, reset_n, lock, mismatch,
                 output frame_stb, mf_pos, tc_bits, mf_lost, expected);
    modport trc (input clk, reset_n, frame_stb, mf_pos, tc_bits, mf_lost, expected,
                 output lock, mismatch);
endinterface : tcm_trace_if

// ==== tcm_trace.sv ====
`timescale 1ns/1ns
// Aligns the 16-byte tandem trace and compares it
module tcm_trace
    import tcm_pkg::*;
(
    tcm_trace_if.trc bus       // Trace carrier
);
    tcm_trace_state_t state_q, state_d;   // Aligner state
    logic [127:0] msg_q;                  // Bytes being assembled
    logic [127:0] prev_q;                 // Last full message
    logic [5:0]   shift_q;                // Partial byte
    logic         tim_q;                  // Mismatch alarm
    wire  in_trace = bus.frame_stb && bus.mf_pos >= TRACE_FIRST && bus.mf_pos <= TRACE_LAST;
    wire  byte_end = in_trace && bus.mf_pos[1:0] == 2'h0;   // 4th frame of byte
    wire  msg_end  = bus.frame_stb && bus.mf_pos == TRACE_LAST;
    wire  [6:0] rel = 7'(bus.mf_pos - TRACE_FIRST);
    wire  [3:0] idx = rel[5:2];                             // Byte index
    wire  [7:0] new_byte = {shift_q, bus.tc_bits};
    wire  [127:0] msg_now = {msg_q[127:8], new_byte};
    // Start marker in byte 0 only
    logic well;
    always_comb begin
        well = msg_now[127];
        for (int i = 1; i < 16; i++) begin
            well = well && !msg_now[127 - 8 * i];
        end
    end
    wire  stable = msg_now == prev_q;
    wire  match  = msg_now == bus.expected;
    // Alignment state machine, stepped at each message end and held in hunt while multiframe is lost
    always_comb begin
        state_d = state_q;
        if (bus.mf_lost) begin
            state_d = TR_HUNT;
        end else if (msg_end) begin
            case (state_q)
                TR_HUNT:    state_d = well ? TR_CONFIRM : TR_HUNT;
                TR_CONFIRM: state_d = (well && stable) ? TR_LOCKED : TR_HUNT;
                TR_LOCKED:  state_d = (well && stable) ? TR_LOCKED : TR_HUNT;
                default:    state_d = TR_HUNT;
            endcase
        end
    end
    // Byte assembly and state registers
    always_ff @(posedge bus.clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            state_q <= TR_HUNT;
            msg_q   <= '0;
            prev_q  <= '0;
            shift_q <= '0;
        end else begin
            state_q <= state_d;
            if (in_trace) begin
                shift_q <= {shift_q[3:0], bus.tc_bits};
            end
            if (byte_end) begin
                msg_q[8 * (15 - idx) +: 8] <= new_byte;
            end
            if (msg_end) begin
                prev_q <= msg_now;
            end
        end
    end
    // Mismatch: set while locked, cleared only on a fresh relock
    always_ff @(posedge bus.clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            tim_q <= 1'b0;
        end else if (msg_end && state_q == TR_LOCKED && state_d == TR_LOCKED && !match) begin
            tim_q <= 1'b1;
        end else if (msg_end && state_q == TR_CONFIRM && state_d == TR_LOCKED && match) begin
            tim_q <= 1'b0;
        end
    end
    assign bus.lock     = state_q == TR_LOCKED;
    assign bus.mismatch = tim_q;
endmodule : tcm_trace

// ==== tcm_monitor.sv ====
`timescale 1ns/1ns
// Four-port tandem connection monitor for the drop bus
module tcm_monitor
    import tcm_pkg::*;
(
    input  wire logic                 clk,                   // Byte clock
    input  wire logic                 reset_n,               // Async reset
    input  wire logic [3:0]           n2_stb,                // N2 byte valid
    input  wire tcm_pkg::tcm_byte_t   n2_byte [4],           // N2 byte
    input  wire logic [6:0]           mf_pos [4],            // Frame 1..76
    input  wire logic [1:0]           bip_calc [4],          // Computed BIP-2
    input  wire logic [3:0]           v4_stb,                // V4 byte valid
    input  wire tcm_pkg::tcm_byte_t   v4_byte [4],           // V4 byte
    input  wire logic [3:0]           tc_enable,             // Error counters on
    input  wire logic [3:0]           block_count_select,    // Block mode
    input  wire logic [3:0]           v4_capture_enable,     // V4 capture
    input  wire logic [127:0]         expected_msg [4],      // Trace to match
    input  wire logic                 rd_stb,                // Read strobe
    input  wire tcm_pkg::tcm_addr_t   rd_addr,               // Read address
    output logic [7:0]                rd_data,               // Read data
    output logic [7:0]                tc_alarm [4]           // Alarm levels
);
    import tcm_pkg::*;

    // Persistence filter: flip after lim frames disagreeing
    function automatic logic [3:0] persist(
        input logic       alarm,
        input logic [2:0] cnt,
        input logic       cond,
        input logic [2:0] lim
    );
        logic [2:0] nxt;
        nxt = 3'(cnt + 3'h1);
        if (cond == alarm) begin
            persist = {alarm, 3'h0};            // Agreement resets run
        end else if (nxt >= lim) begin
            persist = {cond, 3'h0};             // Run long enough
        end else begin
            persist = {alarm, nxt};             // Keep counting
        end
    endfunction : persist

    // Saturating counter with clear-on-read
    function automatic logic [7:0] sat_count(
        input logic [7:0] cnt,
        input logic [1:0] inc,
        input logic       clr
    );
        logic [8:0] sum;
        sum = {1'b0, (clr ? 8'h00 : cnt)} + {7'h00, inc};
        sat_count = sum[8] ? CNT_MAX : sum[7:0];
    endfunction : sat_count

    logic [7:0] port_rd [4];                    // Per-port read data
    logic [3:0] port_hit;                       // Per-port address hit
    logic [7:0] rd_data_q;                      // Registered read data

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            // Alarm state
            logic       uq_q, ais_q, odi_q, rdi_q, lom_q;
            logic [2:0] uq_n_q, ais_n_q, odi_n_q, rdi_n_q, lom_n_q;
            logic [15:0] fas_q;                 // Alignment bits
            // Counters and captured byte
            logic [7:0] bip_q, rei_q, oei_q, v4_q;

            // Frame event decode
            wire        stb   = n2_stb[p];
            wire [7:0]  n2    = n2_byte[p];
            wire        cnt_en = stb && tc_enable[p];
            wire        at_rdi = stb && mf_pos[p] == RDI_POS;
            wire        at_odi = stb && mf_pos[p] == ODI_POS;
            wire        in_fas = stb && mf_pos[p] >= FAS_FIRST && mf_pos[p] <= FAS_LAST;
            wire        fas_end = stb && mf_pos[p] == FAS_LAST;
            wire [15:0] fas_now = {fas_q[13:0], n2[N2_ODI], n2[N2_RDI]};
            wire        mf_bad = fas_now[11:0] != MFAS_PAT;
            wire [2:0]  lom_lim = lom_q ? LOM_CLR_CNT : LOM_SET_CNT;

            // Filter next values
            wire [3:0]  uq_nx  = persist(uq_q, uq_n_q, n2[N2_UNEQ_HI:0] == 6'h00,
                                         PERSIST_FRAMES);
            wire [3:0]  ais_nx = persist(ais_q, ais_n_q, n2[N2_AIS], PERSIST_FRAMES);
            wire [3:0]  odi_nx = persist(odi_q, odi_n_q, n2[N2_ODI], PERSIST_FRAMES);
            wire [3:0]  rdi_nx = persist(rdi_q, rdi_n_q, n2[N2_RDI], PERSIST_FRAMES);
            wire [3:0]  lom_nx = persist(lom_q, lom_n_q, mf_bad, lom_lim);

            // BIP-2 error count per frame
            wire [1:0]  bip_x   = n2[N2_BIP_HI:N2_BIP_LO] ^ bip_calc[p];
            wire [1:0]  bip_sum = {1'b0, bip_x[1]} + {1'b0, bip_x[0]};
            wire [1:0]  bip_inc = block_count_select[p] ? {1'b0, |bip_x} : bip_sum;

            // Register decode
            wire        hit_st  = rd_addr == STATUS_ADDR[p];
            wire        hit_bip = rd_addr == PARITY_ADDR[p];
            wire        hit_rei = rd_addr == REMOTE_ADDR[p];
            wire        hit_oei = rd_addr == OUTGO_ADDR[p];
            wire        hit_v4  = rd_addr == V4_ADDR[p];
            wire        clr_bip = rd_stb && hit_bip;
            wire        clr_rei = rd_stb && hit_rei;
            wire        clr_oei = rd_stb && hit_oei;

            // Trace aligner per port
            tcm_trace_if u_if (
                .clk     (clk),
                .reset_n (reset_n)
            );
            tcm_trace u_trace (
                .bus (u_if.trc)
            );
            assign u_if.frame_stb = stb;
            assign u_if.mf_pos    = mf_pos[p];
            assign u_if.tc_bits   = {n2[N2_ODI], n2[N2_RDI]};
            assign u_if.mf_lost   = lom_q;
            assign u_if.expected  = expected_msg[p];

            // Status byte; bit 0 driven zero
            wire [7:0]  status;
            assign status[ST_UNEQ] = uq_q;
            assign status[ST_AIS]  = ais_q;
            assign status[ST_LOM]  = lom_q;
            assign status[ST_LOL]  = !u_if.lock;
            assign status[ST_TIM]  = u_if.mismatch;
            assign status[ST_ODI]  = odi_q;
            assign status[ST_RDI]  = rdi_q;
            assign status[0]       = 1'b0;

            // Unequipped and AIS filters, once per frame
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    {uq_q, uq_n_q}   <= {1'b0, PCNT_RST};
                    {ais_q, ais_n_q} <= {1'b0, PCNT_RST};
                end else if (stb) begin
                    {uq_q, uq_n_q}   <= uq_nx;
                    {ais_q, ais_n_q} <= ais_nx;
                end
            end

            // ODI and RDI filters, once per multiframe
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    {odi_q, odi_n_q} <= {1'b0, PCNT_RST};
                    {rdi_q, rdi_n_q} <= {1'b0, PCNT_RST};
                end else begin
                    if (at_odi) begin
                        {odi_q, odi_n_q} <= odi_nx;
                    end
                    if (at_rdi) begin
                        {rdi_q, rdi_n_q} <= rdi_nx;
                    end
                end
            end

            // Multiframe alignment check at frame 8
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    fas_q            <= '0;
                    {lom_q, lom_n_q} <= {1'b0, PCNT_RST};
                end else begin
                    if (in_fas) begin
                        fas_q <= fas_now;
                    end
                    if (fas_end) begin
                        {lom_q, lom_n_q} <= lom_nx;
                    end
                end
            end

            // Parity error counter
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    bip_q <= REG_RST;
                end else if (cnt_en || clr_bip) begin
                    bip_q <= sat_count(bip_q, cnt_en ? bip_inc : 2'h0,
                                       clr_bip);
                end
            end

            // Remote and outgoing error counters
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    rei_q <= REG_RST;
                    oei_q <= REG_RST;
                end else begin
                    if (cnt_en || clr_rei) begin
                        rei_q <= sat_count(rei_q, {1'b0, cnt_en && n2[N2_REI]},
                                           clr_rei);
                    end
                    if (cnt_en || clr_oei) begin
                        oei_q <= sat_count(oei_q, {1'b0, cnt_en && n2[N2_OEI]},
                                           clr_oei);
                    end
                end
            end

            // V4 capture, bit 1 of the byte lands in bit 7
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    v4_q <= REG_RST;
                end else if (v4_stb[p] && v4_capture_enable[p]) begin
                    v4_q <= v4_byte[p];
                end
            end

            // Read selection for this port
            assign port_hit[p] = hit_st || hit_bip || hit_rei || hit_oei || hit_v4;
            assign port_rd[p]  = hit_st  ? status :
                                 hit_bip ? bip_q  :
                                 hit_rei ? rei_q  :
                                 hit_oei ? oei_q  :
                                 hit_v4  ? v4_q   : 8'h00;
            assign tc_alarm[p] = status;
        end
    endgenerate

    // Merge the port read paths
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NPORT; i++) begin
            rd_mux = rd_mux | (port_hit[i] ? port_rd[i] : 8'h00);
        end
    end

    // Read data held until the next read; unmapped reads give zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= REG_RST;
        end else if (rd_stb) begin
            rd_data_q <= rd_mux;
        end
    end

    assign rd_data = rd_data_q;
endmodule : tcm_monitor

// ==== tcm_drop_src.sv ====
`timescale 1ns/1ns
// Drop bus source: strobed N2 and V4 bytes per port
module tcm_drop_src
    import tcm_pkg::*;
(
    input  wire logic          clk,          // Byte clock
    output logic [3:0]         n2_stb,       // N2 valid
    output tcm_pkg::tcm_byte_t n2_byte [4],  // N2 byte
    output logic [6:0]         mf_pos [4],   // Frame number
    output logic [1:0]         bip_calc [4], // Computed BIP-2
    output logic [3:0]         v4_stb,       // V4 valid
    output tcm_pkg::tcm_byte_t v4_byte [4]   // V4 byte
);
    logic [6:0] pos_q [4];                   // Next position per port
    // Idle lines before any frame
    initial begin
        n2_stb = 4'h0;
        v4_stb = 4'h0;
        for (int p = 0; p < 4; p++) begin
            n2_byte[p] = 8'h00;
            mf_pos[p] = 7'h00;
            bip_calc[p] = 2'h0;
            v4_byte[p] = 8'h00;
            pos_q[p] = 7'h01;
        end
    end
    // One N2 byte; released lines show the inverse
    task automatic send(input int p, input tcm_pkg::tcm_byte_t b, input logic [1:0] bip);
        @(negedge clk);
        n2_stb[p] = 1'b1;
        n2_byte[p] = b;
        mf_pos[p] = pos_q[p];
        bip_calc[p] = bip;
        @(negedge clk);
        n2_stb[p] = 1'b0;
        n2_byte[p] = ~b;
        mf_pos[p] = ~pos_q[p];
        bip_calc[p] = ~bip;
        pos_q[p] = (pos_q[p] == 7'h4C) ? 7'h01 : pos_q[p] + 7'h01;
    endtask : send
    // One V4 byte
    task automatic send_v4(input int p, input tcm_pkg::tcm_byte_t b);
        @(negedge clk);
        v4_stb[p] = 1'b1;
        v4_byte[p] = b;
        @(negedge clk);
        v4_stb[p] = 1'b0;
        v4_byte[p] = ~b;
    endtask : send_v4
endmodule : tcm_drop_src

// ==== tcm_monitor_checker.sv ====
`timescale 1ns/1ns
// Port 0 filter runs and read path timing
module tcm_monitor_checker
    import tcm_pkg::*;
(
    input wire logic               clk,          // Byte clock
    input wire logic               reset_n,      // Async reset
    input wire logic [3:0]         n2_stb,       // N2 valid
    input wire tcm_pkg::tcm_byte_t n2_byte [4],  // N2 byte
    input wire logic               rd_stb,       // Read strobe
    input wire tcm_pkg::tcm_addr_t rd_addr,      // Read address
    input wire logic [7:0]         rd_data,      // Read data
    input wire logic [7:0]         tc_alarm [4]  // Alarm levels
);
    logic [2:0] ais1_q, ais0_q, uq_q;                  // Consecutive frame runs
    wire        ais_on = n2_byte[0][N2_AIS];           // AIS bit set
    wire        uq_on  = (n2_byte[0][5:0] == 6'h00);   // Bits 3-8 clear
    // Saturating run counter step
    function automatic logic [2:0] bump(input logic [2:0] q, input logic on);
        bump = on ? ((q == 3'h7) ? q : q + 3'h1) : 3'h0;
    endfunction : bump
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Runs advance only on strobed frames
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ais1_q <= 3'h0;
            ais0_q <= 3'h0;
            uq_q   <= 3'h0;
        end else if (n2_stb[0]) begin
            ais1_q <= bump(ais1_q, ais_on);
            ais0_q <= bump(ais0_q, !ais_on);
            uq_q   <= bump(uq_q, uq_on);
        end
    end
    a_ais_set: assert property ($rose(tc_alarm[0][ST_AIS]) |-> ais1_q >= PERSIST_FRAMES)
        else $error("AIS set too early");
    a_ais_clear: assert property ($fell(tc_alarm[0][ST_AIS]) |-> ais0_q >= PERSIST_FRAMES)
        else $error("AIS cleared too early");
    a_uneq_set: assert property ($rose(tc_alarm[0][ST_UNEQ]) |-> uq_q >= PERSIST_FRAMES)
        else $error("unequipped set too early");
    a_unused_zero: assert property (
        (tc_alarm[0][0] | tc_alarm[1][0] | tc_alarm[2][0] | tc_alarm[3][0]) == 1'b0)
        else $error("unused status bit set");
    a_frame_paced: assert property (
        !n2_stb[0] |=> $stable({tc_alarm[0][7:5], tc_alarm[0][2:0]}))
        else $error("alarm moved without a frame");
    a_status_view: assert property (
        rd_stb && rd_addr == STATUS_ADDR[0] |=> rd_data == $past(tc_alarm[0]))
        else $error("status read differs from alarms");
    a_read_clears: assert property (
        (rd_stb && rd_addr == PARITY_ADDR[0] && !n2_stb[0]) ##1 !n2_stb[0]
        ##1 (rd_stb && rd_addr == PARITY_ADDR[0]) |=> rd_data == 8'h00)
        else $error("counter not cleared by read");
    a_data_holds: assert property (!rd_stb |=> $stable(rd_data))
        else $error("read data moved without a read");
endmodule : tcm_monitor_checker

bind tcm_monitor tcm_monitor_checker chk_u (
    .clk(clk), .reset_n(reset_n), .n2_stb(n2_stb), .n2_byte(n2_byte),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .tc_alarm(tc_alarm)
);

// ==== tcm_monitor_tb.sv ====
`timescale 1ns/1ns
// Register and frame sequences against the tandem monitor
module tcm_monitor_tb;
    import tcm_pkg::*;
    localparam logic [127:0] MSG_A = {8'h80, 120'h0102030405060708090A0B0C0D0E0F};
    localparam logic [127:0] MSG_B = {8'h81, 120'h0102030405060708090A0B0C0D0E0F};
    logic         clk, reset_n, rd_stb;              // Clock, reset, read strobe
    logic [3:0]   n2_stb, v4_stb, tc_enable;         // Strobes, counter enables
    logic [3:0]   block_count_select, v4_capture_enable; // Per-port modes
    tcm_byte_t    n2_byte [4], v4_byte [4];          // Drop bytes
    logic [6:0]   mf_pos [4];                        // Frame numbers
    logic [1:0]   bip_calc [4];                      // Computed BIP-2
    logic [127:0] expected_msg [4];                  // Trace to match
    tcm_addr_t    rd_addr;                           // Read address
    logic [7:0]   rd_data, tc_alarm [4];             // Outputs
    int           n_errors, checks_done;             // Tallies
    tcm_monitor dut_u (.clk(clk), .reset_n(reset_n), .n2_stb(n2_stb), .n2_byte(n2_byte),
        .mf_pos(mf_pos), .bip_calc(bip_calc), .v4_stb(v4_stb), .v4_byte(v4_byte),
        .tc_enable(tc_enable), .block_count_select(block_count_select),
        .v4_capture_enable(v4_capture_enable), .expected_msg(expected_msg),
        .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .tc_alarm(tc_alarm));
    tcm_drop_src src_u (.clk(clk), .n2_stb(n2_stb), .n2_byte(n2_byte), .mf_pos(mf_pos),
        .bip_calc(bip_calc), .v4_stb(v4_stb), .v4_byte(v4_byte));
    // 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One register read; address released afterwards
    task automatic rd_chk(input tcm_addr_t a, input tcm_byte_t exp);
        @(negedge clk);
        rd_stb = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_stb = 1'b0;
        rd_addr = ~a;
        check($sformatf("reg %h", a), rd_data, exp);
    endtask : rd_chk
    task automatic al(input int b, input logic exp);
        check($sformatf("alarm bit %0d", b), {7'h00, tc_alarm[0][b]}, {7'h00, exp});
    endtask : al
    // Single frames on port 0, alarm checked after each
    task automatic frames(input int n, input tcm_byte_t v, input int b, input logic last);
        for (int k = 0; k < n; k++) begin
            src_u.send(0, v, 2'b00);
            al(b, (k == n - 1) ? last : !last);
        end
    endtask : frames
    // Whole multiframes on port 0, alarm checked after each
    task automatic mfs(input int n, input logic [127:0] msg, input logic rdi, odi, good,
                       input int b, input logic last);
        tcm_byte_t v;
        for (int k = 0; k < n; k++) begin
            for (int f = 1; f <= 76; f++) begin
                v = 8'h20;
                if (f <= 8) v[1:0] = !good ? 2'b00 : (f == 8) ? 2'b10 : 2'b11;
                else if (f <= 72) v[1:0] = msg[127 - 2 * (f - 9) -: 2];
                else if (f == 73) v[0] = rdi;
                else if (f == 74) v[1] = odi;
                src_u.send(0, v, 2'b00);
            end
            al(b, (k == n - 1) ? last : !last);
        end
    endtask : mfs
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    // Test sequence
    initial begin
        {rd_stb, rd_addr, tc_enable, block_count_select, v4_capture_enable} = '0;
        for (int p = 0; p < 4; p++) expected_msg[p] = MSG_B;
        n_errors = 0;
        checks_done = 0;
        reset_n = 1'b0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        rd_chk(STATUS_ADDR[0], 8'h10);
        rd_chk(PARITY_ADDR[0], 8'h00);
        rd_chk(V4_ADDR[0], 8'h00);
        rd_chk(12'h000, 8'h00);
        $display("test reset done");
        mfs(4, MSG_A, 1'b0, 1'b0, 1'b0, ST_LOM, 1'b1);
        mfs(3, MSG_A, 1'b0, 1'b0, 1'b1, ST_LOM, 1'b0);
        mfs(5, MSG_A, 1'b1, 1'b0, 1'b1, ST_RDI, 1'b1);
        al(ST_ODI, 1'b0);
        mfs(5, MSG_A, 1'b1, 1'b1, 1'b1, ST_ODI, 1'b1);
        mfs(5, MSG_A, 1'b0, 1'b0, 1'b1, ST_RDI, 1'b0);
        al(ST_ODI, 1'b0);
        al(ST_LOL, 1'b0);
        al(ST_TIM, 1'b1);
        expected_msg[0] = MSG_A;
        mfs(1, MSG_A, 1'b0, 1'b0, 1'b1, ST_TIM, 1'b1);
        mfs(1, MSG_B, 1'b0, 1'b0, 1'b1, ST_LOL, 1'b1);
        mfs(1, MSG_A, 1'b0, 1'b0, 1'b1, ST_TIM, 1'b1);
        mfs(1, MSG_A, 1'b0, 1'b0, 1'b1, 0, 1'b0);
        mfs(1, MSG_A, 1'b0, 1'b0, 1'b1, ST_TIM, 1'b0);
        al(ST_LOL, 1'b0);
        $display("test multiframe done");
        frames(5, 8'h30, ST_AIS, 1'b1);
        frames(5, 8'h20, ST_AIS, 1'b0);
        frames(5, 8'h00, ST_UNEQ, 1'b1);
        frames(5, 8'h20, ST_UNEQ, 1'b0);
        $display("test filters done");
        tc_enable = 4'hF;
        for (int p = 0; p < 4; p++) begin
            src_u.send(p, 8'h2C, 2'b11);
            rd_chk(PARITY_ADDR[p], 8'h02);
            rd_chk(REMOTE_ADDR[p], 8'h01);
            rd_chk(OUTGO_ADDR[p], 8'h01);
            block_count_select[p] = 1'b1;
            src_u.send(p, 8'h2C, 2'b11);
            rd_chk(PARITY_ADDR[p], 8'h01);
            block_count_select[p] = 1'b0;
            tc_enable[p] = 1'b0;
            src_u.send(p, 8'h2C, 2'b11);
            rd_chk(REMOTE_ADDR[p], 8'h01);
            tc_enable[p] = 1'b1;
            v4_capture_enable[p] = 1'b1;
            src_u.send_v4(p, 8'hA5);
            rd_chk(V4_ADDR[p], 8'hA5);
            v4_capture_enable[p] = 1'b0;
            src_u.send_v4(p, 8'h3C);
            rd_chk(V4_ADDR[p], 8'hA5);
            if (p > 0) rd_chk(STATUS_ADDR[p], 8'h10);
        end
        repeat (130) src_u.send(0, 8'h2C, 2'b11);
        rd_chk(PARITY_ADDR[0], 8'hFF);
        rd_chk(PARITY_ADDR[0], 8'h00);
        rd_chk(REMOTE_ADDR[0], 8'h82);
        $display("test counters done");
        finish_test();
    end
endmodule : tcm_monitor_tb
